//--- hdl/dcc_pkg.sv
// Package of constants and types shared by the dual comparator control block.
package dcc_pkg;
  // Special-function addresses of the two control registers.
  localparam logic [7:0] DCC_ADDR_CMP0 = 8'h9E;
  localparam logic [7:0] DCC_ADDR_CMP1 = 8'h9F;
  localparam logic [7:0] DCC_CTRL_RESET = 8'h00;
  // Bit positions inside a control register.
  localparam int DCC_BIT_ENABLE = 7;
  localparam int DCC_BIT_STATE = 6;
  localparam int DCC_BIT_RISE = 5;
  localparam int DCC_BIT_FALL = 4;
  localparam int DCC_POS_HI = 3;
  localparam int DCC_POS_LO = 2;
  localparam int DCC_NEG_HI = 1;
  localparam int DCC_NEG_LO = 0;
  localparam logic [1:0] DCC_HYST_NONE = 2'h0;
  localparam logic [1:0] DCC_HYST_MAX = 2'h3;
  localparam int DCC_NUM_CMP = 2;

  // Analog-side settings for one comparator.
  typedef struct packed {
    logic enable;
    logic [1:0] posHyst;
    logic [1:0] negHyst;
  } dcc_analog_t;

  // Register bus write or read request.
  typedef struct packed {
    logic wrEn;
    logic rdEn;
    logic [7:0] addr;
    logic [7:0] wrData;
  } dcc_bus_t;
endpackage

//--- hdl/dcc_edge_detect.sv
// Two-stage synchroniser and edge detector for one comparator output.
`timescale 1ns/1ps
module dcc_edge_detect (
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic rawIn,
  output logic syncOut,
  output logic rise,
  output logic fall
);
  import dcc_pkg::*;
  logic meta_q, meta_d, sync_q, sync_d, prev_q, prev_d;

  // Next values: the first stage feeds only the second stage.
  always_comb begin
    meta_d = rawIn;
    sync_d = meta_q;
    prev_d = sync_q;
  end

  // Registers of the synchroniser and the previous sample.
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      meta_q <= 1'b0;
      sync_q <= 1'b0;
      prev_q <= 1'b0;
    end else begin
      meta_q <= meta_d;
      sync_q <= sync_d;
      prev_q <= prev_d;
    end
  end

  // Compare successive synchronised samples.
  assign syncOut = sync_q;
  assign rise = sync_q & ~prev_q;
  assign fall = ~sync_q & prev_q;
endmodule

//--- hdl/dcc_top.sv
// Control and status logic for two on-chip analog comparators.
//
// Notes on behaviour
// (RL1) Each comparator has an enable bit at bit 7; one turns it on, zero shuts it down.
// (RL2) A disabled comparator drives its routed output low and raises no events.
// (RL3) Bit 6 reads the live comparator output, one when plus input exceeds minus input.
// (RL4) Rising and falling output transitions are both detected and both can interrupt.
// (RL5) A rising transition sets the rising-edge flag at bit 5.
// (RL6) A falling transition sets the falling-edge flag at bit 4.
// (RL7) Edge flags are sticky; only a software write of zero clears them.
// (RL8) Bits 3-2 select positive hysteresis, code 00 meaning none.
// (RL9) Bits 1-0 select negative hysteresis, code 11 meaning the largest.
// (RL10) Comparator0 may request a system reset; Comparator1 cannot.
// (RL11) Comparator1 is identical but controlled at address 0x9F.
// (RL12) Each output can be routed to a pin as open-drain or push-pull.
// (RL13) Edges are found from a two-stage synchronised copy of the output.
// (RL14) A hardware set of a flag wins over a software clear in the same cycle.
`timescale 1ns/1ps
module dcc_top (
  input wire logic core_clk,
  input wire logic reset_n,
  input dcc_pkg::dcc_bus_t busReq,
  input wire logic cmp0ResetEnable,
  input wire logic [1:0] cmpRaw,
  input wire logic [1:0] pinRouteEn,
  input wire logic [1:0] pinPushPull,
  output logic [7:0] rdData,
  output dcc_pkg::dcc_analog_t cmp0Analog,
  output dcc_pkg::dcc_analog_t cmp1Analog,
  output logic [1:0] cmpRouted,
  output logic [1:0] pinOut,
  output logic [1:0] pinOe,
  output logic [1:0] riseIrq,
  output logic [1:0] fallIrq,
  output logic cmp0ResetReq
);
  import dcc_pkg::*;

  logic [DCC_NUM_CMP-1:0] enable_q, enable_d, rise_q, rise_d, fall_q, fall_d;
  logic [1:0] posHyst_q [DCC_NUM_CMP];
  logic [1:0] posHyst_d [DCC_NUM_CMP];
  logic [1:0] negHyst_q [DCC_NUM_CMP];
  logic [1:0] negHyst_d [DCC_NUM_CMP];
  logic [DCC_NUM_CMP-1:0] syncOut, riseDet, fallDet, hit;
  logic [7:0] rdData_d;
  logic [1:0] routed_d, pinOut_d, pinOe_d;
  logic resetReq_d;
  dcc_analog_t an0_d, an1_d;

  generate
    for (genvar i = 0; i < DCC_NUM_CMP; i++) begin : gCmp
      // Each channel has its own synchroniser and edge detector.
      dcc_edge_detect uEdge (
        .core_clk(core_clk),
        .reset_n(reset_n),
        .rawIn(cmpRaw[i]),
        .syncOut(syncOut[i]),
        .rise(riseDet[i]),
        .fall(fallDet[i])
      ); // see (RL13)
      assign hit[i] = busReq.wrEn &&
        (busReq.addr == (i == 0 ? DCC_ADDR_CMP0 : DCC_ADDR_CMP1)); // see (RL11)

      // Register next values; a write of one to a flag leaves it as it was.
      always_comb begin
        enable_d[i] = enable_q[i];
        posHyst_d[i] = posHyst_q[i];
        negHyst_d[i] = negHyst_q[i];
        rise_d[i] = rise_q[i];
        fall_d[i] = fall_q[i];
        if (hit[i]) begin
          enable_d[i] = busReq.wrData[DCC_BIT_ENABLE]; // see (RL1)
          posHyst_d[i] = busReq.wrData[DCC_POS_HI:DCC_POS_LO]; // see (RL8)
          negHyst_d[i] = busReq.wrData[DCC_NEG_HI:DCC_NEG_LO]; // see (RL9)
          rise_d[i] = rise_q[i] & busReq.wrData[DCC_BIT_RISE]; // see (RL7)
          fall_d[i] = fall_q[i] & busReq.wrData[DCC_BIT_FALL]; // see (RL7)
        end
        // Events are applied last so a set beats a same-cycle clear.
        if (enable_q[i] && riseDet[i]) begin
          rise_d[i] = 1'b1; // see (RL5) (RL14) (RL2)
        end
        if (enable_q[i] && fallDet[i]) begin
          fall_d[i] = 1'b1; // see (RL6) (RL14) (RL2)
        end
      end

      // Control state registers.
      always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
          enable_q[i] <= 1'b0;
          posHyst_q[i] <= DCC_HYST_NONE;
          negHyst_q[i] <= DCC_HYST_NONE;
          rise_q[i] <= 1'b0;
          fall_q[i] <= 1'b0;
        end else begin
          enable_q[i] <= enable_d[i];
          posHyst_q[i] <= posHyst_d[i];
          negHyst_q[i] <= negHyst_d[i];
          rise_q[i] <= rise_d[i];
          fall_q[i] <= fall_d[i];
        end
      end

      // Output routing; open-drain only drives while the output is low.
      always_comb begin
        routed_d[i] = enable_q[i] & syncOut[i]; // see (RL2)
        pinOut_d[i] = routed_d[i];
        pinOe_d[i] = pinRouteEn[i] & (pinPushPull[i] | ~routed_d[i]); // see (RL12)
      end
    end
  endgenerate

  // Read mux and analog controls; unmapped addresses read as zero.
  always_comb begin
    rdData_d = 8'h00;
    if (busReq.rdEn && busReq.addr == DCC_ADDR_CMP0) begin
      rdData_d = {enable_q[0], syncOut[0], rise_q[0], fall_q[0],
                  posHyst_q[0], negHyst_q[0]}; // see (RL3)
    end else if (busReq.rdEn && busReq.addr == DCC_ADDR_CMP1) begin
      rdData_d = {enable_q[1], syncOut[1], rise_q[1], fall_q[1],
                  posHyst_q[1], negHyst_q[1]}; // see (RL3) (RL11)
    end
    an0_d = '{enable: enable_q[0], posHyst: posHyst_q[0], negHyst: negHyst_q[0]};
    an1_d = '{enable: enable_q[1], posHyst: posHyst_q[1], negHyst: negHyst_q[1]};
    // Only comparator0 can request reset, and only while enabled and low.
    resetReq_d = cmp0ResetEnable & enable_q[0] & ~syncOut[0]; // see (RL10)
  end

  // All outputs are registered, trading one cycle of latency for clean timing.
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      rdData <= DCC_CTRL_RESET;
      cmp0Analog <= '0;
      cmp1Analog <= '0;
      cmpRouted <= 2'h0;
      pinOut <= 2'h0;
      pinOe <= 2'h0;
      riseIrq <= 2'h0;
      fallIrq <= 2'h0;
      cmp0ResetReq <= 1'b0;
    end else begin
      rdData <= rdData_d;
      cmp0Analog <= an0_d;
      cmp1Analog <= an1_d;
      cmpRouted <= routed_d;
      pinOut <= pinOut_d;
      pinOe <= pinOe_d;
      riseIrq <= rise_d; // see (RL4)
      fallIrq <= fall_d; // see (RL4)
      cmp0ResetReq <= resetReq_d;
    end
  end

  // Named sequence for a rising edge on an enabled comparator0.
  sequence sRise0;
    enable_q[0] && riseDet[0];
  endsequence

  chk_rise_sets_flag: assert property (@(posedge core_clk) disable iff (!reset_n)
    sRise0 |=> rise_q[0]) else $error("rise flag not set"); // see (RL5) (RL14)
  chk_fall_sets_flag: assert property (@(posedge core_clk) disable iff (!reset_n)
    enable_q[1] && fallDet[1] |=> fall_q[1]) else $error("fall flag not set"); // see (RL6)
  chk_flag_sticky: assert property (@(posedge core_clk) disable iff (!reset_n)
    rise_q[0] && !hit[0] |=> rise_q[0]) else $error("rise flag dropped"); // see (RL7)
  chk_disabled_no_event: assert property (@(posedge core_clk) disable iff (!reset_n)
    !enable_q[0] && !rise_q[0] && !hit[0] |=> !rise_q[0])
    else $error("event while disabled"); // see (RL2)
  chk_routed_low_off: assert property (@(posedge core_clk) disable iff (!reset_n)
    !enable_q[1] |=> !cmpRouted[1]) else $error("routed output not low"); // see (RL2)
  chk_enable_write: assert property (@(posedge core_clk) disable iff (!reset_n)
    hit[1] |=> enable_q[1] == $past(busReq.wrData[DCC_BIT_ENABLE]))
    else $error("enable not written"); // see (RL1) (RL11)
  chk_state_read: assert property (@(posedge core_clk) disable iff (!reset_n)
    busReq.rdEn && busReq.addr == DCC_ADDR_CMP0 |=> rdData[DCC_BIT_STATE] == $past(syncOut[0]))
    else $error("state bit wrong"); // see (RL3)
  chk_sync_delay: assert property (@(posedge core_clk) disable iff (!reset_n)
    $rose(cmpRaw[0]) ##1 cmpRaw[0] |=> syncOut[0]) else $error("sync latency wrong"); // see (RL13)
  chk_hyst_write: assert property (@(posedge core_clk) disable iff (!reset_n)
    hit[0] |=> ##1 cmp0Analog.negHyst == $past(busReq.wrData[DCC_NEG_HI:DCC_NEG_LO], 2))
    else $error("hysteresis not applied"); // see (RL8) (RL9)

  // Named steps for a flag clash and for a clean clear.
  sequence sSetClash1;
    hit[1] && enable_q[1] && riseDet[1];
  endsequence
  sequence sClearFall0;
    hit[0] && !busReq.wrData[DCC_BIT_FALL] && !(enable_q[0] && fallDet[0]);
  endsequence

  // A shut-down comparator0 must never pull the system into reset.
  chk_req_needs_en: assert property (@(posedge core_clk) disable iff (!reset_n) // see (RL10)
    !enable_q[0] |=> !cmp0ResetReq)
    else $error("reset request while disabled");
  chk_pin_low_off: assert property (@(posedge core_clk) disable iff (!reset_n) // see (RL2)
    !enable_q[0] |=> !pinOut[0])
    else $error("pin not low while disabled");

  // Pin drive: open-drain releases a high level, push-pull always drives.
  chk_open_drain: assert property (@(posedge core_clk) disable iff (!reset_n) // see (RL12)
    pinRouteEn[0] && !pinPushPull[0] && routed_d[0] |=> !pinOe[0])
    else $error("open-drain drove a high level");
  chk_push_pull: assert property (@(posedge core_clk) disable iff (!reset_n) // see (RL12)
    pinRouteEn[1] && pinPushPull[1] |=> pinOe[1])
    else $error("push-pull pin not driven");

  // Interrupt lines mirror the sticky flags so no edge is lost to the handler.
  chk_irq_follow: assert property (@(posedge core_clk) disable iff (!reset_n) // see (RL4)
    riseIrq == rise_q && fallIrq == fall_q)
    else $error("interrupt line differs from flag");

  // Flag ownership: hardware only sets, software clears, set wins a clash.
  chk_set_beats_clear: assert property (@(posedge core_clk) disable iff (!reset_n) // see (RL14)
    sSetClash1 |=> rise_q[1])
    else $error("clear beat a same-cycle set");
  chk_fall_sticky: assert property (@(posedge core_clk) disable iff (!reset_n) // see (RL7)
    fall_q[1] && !hit[1] |=> fall_q[1])
    else $error("fall flag dropped");
  chk_clear_works: assert property (@(posedge core_clk) disable iff (!reset_n) // see (RL7)
    sClearFall0 |=> !fall_q[0])
    else $error("fall flag not cleared");

  // Comparator1 register reads and analog settings match its own writes.
  chk_read_cmp1: assert property (@(posedge core_clk) disable iff (!reset_n) // see (RL11)
    busReq.rdEn && busReq.addr == DCC_ADDR_CMP1 |=> rdData[DCC_BIT_ENABLE] == $past(enable_q[1]))
    else $error("comparator1 read wrong");
  chk_pos_hyst: assert property (@(posedge core_clk) disable iff (!reset_n) // see (RL8)
    hit[1] |=> ##1 cmp1Analog.posHyst == $past(busReq.wrData[DCC_POS_HI:DCC_POS_LO], 2))
    else $error("positive hysteresis not applied");
endmodule

//--- verif/dcc_cmp_front.sv
// Behavioural model of the two analog comparator front ends.
`timescale 1ns/1ps
module dcc_cmp_front #(
  parameter int RESP_NS = 7
) (
  input wire logic [15:0] plusLvl,
  input wire logic [15:0] minusLvl,
  output logic [1:0] cmpRaw
);
  // Output is high when plus exceeds minus; it settles off the clock edge, as analog would.
  assign #RESP_NS cmpRaw = {plusLvl[15:8] > minusLvl[15:8], plusLvl[7:0] > minusLvl[7:0]};
endmodule

//--- verif/tb_dual_comparator_control.sv
// Self-checking testbench for the dual comparator control block.
`timescale 1ns/1ps
module tb_dual_comparator_control;
  import dcc_pkg::*;
  logic core_clk = 1'b0;
  logic reset_n = 1'b0;
  dcc_bus_t busReq = '0;
  logic cmp0ResetEnable = 1'b1;
  logic [1:0] pinRouteEn = 2'h3;
  logic [1:0] pinPushPull = 2'h0;
  logic [15:0] plusLvl = 16'h4040;
  logic [15:0] minusLvl = 16'h8080;
  logic [1:0] cmpRaw, cmpRouted, pinOut, pinOe, riseIrq, fallIrq;
  logic [7:0] rdData, got, a, d;
  logic cmp0ResetReq;
  dcc_analog_t cmp0Analog, cmp1Analog;
  logic [31:0] seed = 32'h078E;
  int errors = 0;
  int n_compared = 0;

  dcc_cmp_front front (.plusLvl(plusLvl), .minusLvl(minusLvl), .cmpRaw(cmpRaw));
  dcc_top dut (.core_clk(core_clk), .reset_n(reset_n), .busReq(busReq),
    .cmp0ResetEnable(cmp0ResetEnable), .cmpRaw(cmpRaw), .pinRouteEn(pinRouteEn),
    .pinPushPull(pinPushPull), .rdData(rdData), .cmp0Analog(cmp0Analog),
    .cmp1Analog(cmp1Analog), .cmpRouted(cmpRouted), .pinOut(pinOut), .pinOe(pinOe),
    .riseIrq(riseIrq), .fallIrq(fallIrq), .cmp0ResetReq(cmp0ResetReq));

  // Free-running core clock.
  always #20 core_clk = ~core_clk;

  // Repeatable pseudo-random source and expectation helpers.
  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction
  function automatic logic [7:0] expReg(input logic [7:0] w);
    return w & 8'h8F;
  endfunction
  function automatic logic [4:0] expAna(input logic [7:0] w);
    return {w[7], w[3:0]};
  endfunction

  // Bus tasks hold each strobe for exactly one sampling edge.
  task automatic chk(input logic [7:0] g, input logic [7:0] e, input string m);
    n_compared++;
    if (g !== e) begin
      errors++;
      $display("CHECK FAILED %0t %s: %h vs %h", $time, m, g, e);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask
  task automatic wr(input logic [7:0] ad, input logic [7:0] wd);
    @(posedge core_clk) busReq <= '{1'b1, 1'b0, ad, wd};
    @(posedge core_clk) busReq <= '0;
  endtask
  task automatic rd(input logic [7:0] ad, output logic [7:0] rv);
    @(posedge core_clk) busReq <= '{1'b0, 1'b1, ad, 8'h00};
    @(posedge core_clk) busReq <= '0;
    #1 rv = rdData;
  endtask
  // Random levels keep a clear margin around the fixed minus level.
  task automatic lvl(input int k, input logic hi);
    seed = xs(seed);
    @(posedge core_clk) plusLvl[k*8 +: 8] <= hi ? 8'h81 + seed[5:0] : {1'b0, seed[6:0]};
  endtask
  task automatic end_of_test();
    $display("compared %0d mismatches %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // A hang is cut short here and counted as a mismatch.
  initial begin
    #3000000;
    errors++;
    end_of_test();
  end

  // Main sequence: unmapped access, reset values, edges per comparator, random writes.
  initial begin
    repeat (3) @(posedge core_clk);
    reset_n <= 1'b1;
    seed = xs(seed);
    pinPushPull <= seed[1:0];
    wr(8'hA0, 8'hFF);
    rd(8'hA0, got);
    chk(got, 8'h00, "unmapped");
    rd(DCC_ADDR_CMP0, got);
    chk(got, DCC_CTRL_RESET, "reset0");
    rd(DCC_ADDR_CMP1, got);
    chk(got, DCC_CTRL_RESET, "reset1");
    $display("done reset");
    for (int k = 0; k < 2; k++) begin
      a = k ? DCC_ADDR_CMP1 : DCC_ADDR_CMP0;
      wr(a, 8'h80);
      lvl(k, 1'b1);
      tick(6);
      rd(a, got);
      chk(got, 8'hE0, "rise flag");
      chk({riseIrq[k], cmpRouted[k], pinOe[k], cmp0ResetReq}, {2'h3, pinPushPull[k], 1'b0}, "rise");
      lvl(k, 1'b0);
      tick(6);
      rd(a, got);
      chk(got, 8'hB0, "fall flag");
      chk({fallIrq[k], pinOe[k], pinOut[k], cmp0ResetReq}, {3'h6, k == 0}, "fall");
      wr(a, 8'hB0);
      rd(a, got);
      chk(got, 8'hB0, "write one keeps");
      wr(a, 8'h80);
      rd(a, got);
      chk(got, 8'h80, "write zero clears");
      wr(a, 8'h00);
      lvl(k, 1'b1);
      tick(6);
      rd(a, got);
      chk(got & 8'hBF, 8'h00, "disabled events");
      chk({cmpRouted[k], riseIrq[k]}, 8'h00, "disabled output");
      lvl(k, 1'b0);
      tick(6);
      $display("done edges %0d", k);
    end
    for (int j = 0; j < 32; j++) begin
      seed = xs(seed);
      d = {seed[7:4], j[3:0]};
      a = j[4] ? DCC_ADDR_CMP1 : DCC_ADDR_CMP0;
      wr(a, d);
      rd(a, got);
      chk(got, expReg(d), "register write");
      chk({3'h0, j[4] ? cmp1Analog : cmp0Analog}, {3'h0, expAna(d)}, "analog");
    end
    $display("done random writes");
    end_of_test();
  end
endmodule
